//--- verilog/i2c_target_defines.vh
// Constants of the two-wire target block: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef I2C_TARGET_DEFINES_VH
`define I2C_TARGET_DEFINES_VH
// ==========================================================================
// Register indices and byte addresses
`define REG_IDX_OWN_ID 8'h0C
`define REG_IDX_SHIFT_DATA 8'h0D
`define REG_IDX_ID_MASK 8'h0E
`define REG_IDX_CTRL 8'h0A
`define REG_IDX_STATUS 8'h0B
`define REG_IDX_IRQ_MASK 8'h10
`define ADDR_OWN_ID 8'h30
`define ADDR_SHIFT_DATA 8'h34
`define ADDR_ID_MASK 8'h38
`define ADDR_CTRL 8'h28
`define ADDR_STATUS 8'h2C
`define ADDR_IRQ_MASK 8'h40
// ==========================================================================
// Reset values
`define RST_OWN_ID 8'h00
`define RST_SHIFT_DATA 8'h00
`define RST_ID_MASK 8'h00
`define RST_IRQ_MASK 8'h00
// ==========================================================================
// Field positions
`define ST_BYTE_DONE 7
`define ST_MATCH_STOP 6
`define ST_STRETCH 5
`define ST_RX_ACK 4
`define ST_DIR 1
`define ST_CAUSE 0
`define CTRL_REPLY 2
`define MASK_DUAL 0
`define GC_ENABLE 0
`define TENBIT_PREFIX 5'h1E
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

//--- verilog/i2c_target.v
// Two-wire bus target: address match, direction and cause flags, shift data access.
// Assumes an AXI4-Lite master on ref_clk and pins sampled from outside the clock domain.
// How it works
// - Direction flag holds read/write bit of the last matched address byte received.
// - Cause bit reads zero after a stop that ends an addressed transfer, one after address match.
// - Match-or-stop flag sets when received address is recognised.
// - Own address bits 7:1 compared; bit 0 enables general call.
// - Data register is the physical bus shift register.
// - Software writes to data are ignored while a byte shifts.
// - Data valid or accepted only while clock is stretched.
// - Data access while stretched starts the next bus operation.
// - Dual select zero: mask ones force address bits to match.
// - Dual select one: mask field is a second full address.
// - Mask register holds address in bits 7:1, select in bit 0.
// - Reply choice zero sends ACK, one sends NACK.
// - Stretch indicator and clock low while an event flag is set.
// - Byte-done flag clears on data access or valid command.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "i2c_target_defines.vh"
module i2c_target #(
    parameter AW = 8
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_n,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    output wire irq
);
// ==========================================================================
// Pin synchronisers and bus condition detection
reg [1:0] scl_sync;
reg [1:0] sda_sync;
reg scl_q;
reg sda_q;
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        scl_sync <= 2'b11;
        sda_sync <= 2'b11;
        scl_q <= 1'b1;
        sda_q <= 1'b1;
    end else begin
        scl_sync <= {scl_sync[0], scl_in};
        sda_sync <= {sda_sync[0], sda_in};
        scl_q <= scl_sync[1];
        sda_q <= sda_sync[1];
    end
end
wire scl_rise = scl_sync[1] & ~scl_q;
wire scl_fall = ~scl_sync[1] & scl_q;
wire start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
wire stop_cond = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
// ==========================================================================
// Registers
reg [7:0] own_id_reg;
reg [7:0] shift_data_reg;
reg [7:0] id_mask_reg;
reg [7:0] irq_mask;
reg reply_choice;
reg byte_done_flag;
reg match_or_stop_flag;
reg match_cause_bit;
reg dir_flag;
reg rx_ack;
wire scl_stretch_active = byte_done_flag | match_or_stop_flag;
reg scl_hold;
// The pin is pulled only once the clock is low, so a high phase already begun is never cut short.
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
        scl_hold <= 1'b0;
    else
        scl_hold <= scl_stretch_active & (scl_hold | ~scl_sync[1]);
end
wire [7:0] status = {byte_done_flag, match_or_stop_flag, scl_stretch_active, rx_ack,
                     2'b00, dir_flag, match_cause_bit};
assign irq = |(status & irq_mask);
// ==========================================================================
// Address match
function addr_hit;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] msk;
    begin
        if (msk[`MASK_DUAL])
            addr_hit = (rx[7:1] == own[7:1]) | (rx[7:1] == msk[7:1]);
        else
            addr_hit = &(~(rx[7:1] ^ own[7:1]) | msk[7:1]);
    end
endfunction
// ==========================================================================
// Bus state machine
localparam ST_IDLE = 6'b000001;
localparam ST_ADDR = 6'b000010;
localparam ST_AACK = 6'b000100;
localparam ST_HOLD = 6'b001000;
localparam ST_DATA = 6'b010000;
localparam ST_DACK = 6'b100000;
reg [5:0] state;
reg [3:0] bit_cnt;
reg sda_low;
reg send_nack;
reg addressed;
wire busy = (state == ST_ADDR) | (state == ST_DATA);
// Software access handshakes: a write is taken when both channels are present, a read on its address alone.
wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_arready = rd_go;
wire wr_data = wr_go & (s_axi_awaddr == `ADDR_SHIFT_DATA) & s_axi_wstrb[0];
wire rd_data = rd_go & (s_axi_araddr == `ADDR_SHIFT_DATA);
wire wr_ctrl = wr_go & (s_axi_awaddr == `ADDR_CTRL) & s_axi_wstrb[0];
wire wr_stat = wr_go & (s_axi_awaddr == `ADDR_STATUS) & s_axi_wstrb[0];
// Data access only counts while the clock is stretched.
wire data_kick = (rd_data | wr_data) & scl_stretch_active & (state == ST_HOLD);
wire cmd_kick = wr_ctrl & s_axi_wdata[1] & scl_stretch_active;
wire kick = data_kick | cmd_kick;
wire [7:0] rx_byte = {shift_data_reg[6:0], sda_sync[1]};
wire gc_hit = (rx_byte == 8'h00) & own_id_reg[`GC_ENABLE];
wire id_hit = addr_hit(rx_byte, own_id_reg, id_mask_reg) | gc_hit;
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
        send_nack <= 1'b0;
        addressed <= 1'b0;
        shift_data_reg <= `RST_SHIFT_DATA;
        byte_done_flag <= 1'b0;
        match_or_stop_flag <= 1'b0;
        match_cause_bit <= 1'b0;
        dir_flag <= 1'b0;
        rx_ack <= 1'b0;
    end else begin
        if (wr_stat & s_axi_wdata[`ST_BYTE_DONE])
            byte_done_flag <= 1'b0;
        if (wr_stat & s_axi_wdata[`ST_MATCH_STOP])
            match_or_stop_flag <= 1'b0;
        if (kick) begin
            byte_done_flag <= 1'b0;
            match_or_stop_flag <= 1'b0;
        end
        // Writes while shifting never reach the shift register.
        if (wr_data & ~busy & scl_stretch_active)
            shift_data_reg <= s_axi_wdata[7:0];
        if (start_cond) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
            addressed <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_low <= 1'b0;
            addressed <= 1'b0;
            // A refused byte returns the machine to idle, so being addressed is kept apart.
            if (addressed) begin
                match_or_stop_flag <= 1'b1;
                match_cause_bit <= 1'b0;
            end
        end else begin
            case (state)
            ST_ADDR, ST_DATA: begin
                if (scl_rise & (state == ST_ADDR | ~dir_flag)) begin
                    shift_data_reg <= rx_byte;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == 4'h7) begin
                        if (state == ST_ADDR) begin
                            if (id_hit) begin
                                match_or_stop_flag <= 1'b1;
                                match_cause_bit <= 1'b1;
                                dir_flag <= sda_sync[1];
                                addressed <= 1'b1;
                                state <= ST_HOLD;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            byte_done_flag <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                end else if (scl_fall & (state == ST_DATA) & dir_flag) begin
                    sda_low <= ~shift_data_reg[7];
                    shift_data_reg <= {shift_data_reg[6:0], 1'b0};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_rise & dir_flag & (bit_cnt == 4'h8)) begin
                    rx_ack <= sda_sync[1];
                    byte_done_flag <= 1'b1;
                    state <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (kick) begin
                    send_nack <= reply_choice;
                    // After an address match or while receiving: drive the acknowledge.
                    if (~dir_flag | match_cause_bit) begin
                        sda_low <= ~reply_choice;
                        state <= ST_AACK;
                    end else begin
                        // Transmit: drive the first data bit, bit 7, onto the line.
                        sda_low <= ~shift_data_reg[7];
                        shift_data_reg <= {shift_data_reg[6:0], 1'b0};
                        bit_cnt <= 4'h1;
                        state <= ST_DATA;
                    end
                end
            end
            ST_AACK: begin
                if (scl_fall) begin
                    bit_cnt <= 4'h0;
                    if (send_nack) begin
                        sda_low <= 1'b0;
                        state <= ST_IDLE;
                    end else if (dir_flag) begin
                        sda_low <= 1'b0;
                        state <= ST_HOLD;
                        byte_done_flag <= 1'b1;
                    end else begin
                        sda_low <= 1'b0;
                        state <= ST_DATA;
                    end
                end
            end
            ST_DACK: state <= ST_IDLE;
            default: state <= ST_IDLE;
            endcase
            if ((state == ST_DATA) & dir_flag & scl_fall & (bit_cnt == 4'h8))
                sda_low <= 1'b0;
        end
    end
end
assign scl_out = 1'b0;
assign scl_oe_n = ~scl_hold;
assign sda_out = 1'b0;
assign sda_oe_n = ~sda_low;
// ==========================================================================
// Register bus writes and answers
reg [7:0] rd_mux;
always @* begin
    case (s_axi_araddr)
    `ADDR_OWN_ID: rd_mux = own_id_reg;
    `ADDR_SHIFT_DATA: rd_mux = shift_data_reg;
    `ADDR_ID_MASK: rd_mux = id_mask_reg;
    `ADDR_CTRL: rd_mux = {5'h00, reply_choice, 2'b00};
    `ADDR_STATUS: rd_mux = status;
    `ADDR_IRQ_MASK: rd_mux = irq_mask;
    default: rd_mux = 8'h00;
    endcase
end
function mapped;
    input [AW-1:0] a;
    begin
        mapped = (a == `ADDR_OWN_ID) | (a == `ADDR_SHIFT_DATA) | (a == `ADDR_ID_MASK) |
                 (a == `ADDR_CTRL) | (a == `ADDR_STATUS) | (a == `ADDR_IRQ_MASK);
    end
endfunction
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        own_id_reg <= `RST_OWN_ID;
        id_mask_reg <= `RST_ID_MASK;
        irq_mask <= `RST_IRQ_MASK;
        reply_choice <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `AXI_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `AXI_OKAY;
        s_axi_rdata <= 32'h00000000;
    end else begin
        if (wr_go & s_axi_wstrb[0]) begin
            if (s_axi_awaddr == `ADDR_OWN_ID)
                own_id_reg <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `ADDR_ID_MASK)
                id_mask_reg <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `ADDR_IRQ_MASK)
                irq_mask <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `ADDR_CTRL)
                reply_choice <= s_axi_wdata[`CTRL_REPLY];
        end
        if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(s_axi_awaddr) ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mux};
            s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end
endmodule

//--- test/i2c_target_assertions.sv
// Checker for the two-wire target: register bus answers and pin drive relations.
// Assumes it is bound to i2c_target and sees only that module's ports.
`timescale 1ns/1ps
`include "i2c_target_defines.vh"
module i2c_target_assertions #(
    parameter AW = 8
) (
    input wire ref_clk,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe_n,
    input wire sda_out,
    input wire sda_oe_n
);
    // ======================================================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire mapped = s_axi_araddr == `ADDR_OWN_ID || s_axi_araddr == `ADDR_SHIFT_DATA ||
        s_axi_araddr == `ADDR_ID_MASK || s_axi_araddr == `ADDR_CTRL ||
        s_axi_araddr == `ADDR_STATUS || s_axi_araddr == `ADDR_IRQ_MASK;
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=>
        s_axi_bvalid) else $error("write not answered");
    chk_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    chk_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && !mapped |=>
        s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_scl_drive: assert property (!scl_oe_n |-> !scl_out)
        else $error("clock driven high");
    chk_hold_low: assert property ($fell(scl_oe_n) |-> !$past(scl_in, 3))
        else $error("clock hold began while clock high");
    chk_sda_drive: assert property (!sda_oe_n |-> !sda_out)
        else $error("data driven high");
    cov_stretch: cover property ($fell(scl_oe_n));
    cov_ack_drive: cover property ($fell(sda_oe_n));
    cov_unmapped: cover property (s_axi_arvalid && !mapped);
endmodule
bind i2c_target i2c_target_assertions #(.AW(AW)) chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n)
);

//--- test/i2c_bus_master.sv
// Behavioural two-wire bus controller on the far side of the target.
// Assumes open-drain wires resolved by the bench with pull-ups.
`timescale 1ns/1ps
module i2c_bus_master (
    output reg scl_drv,
    output reg sda_drv,
    input wire scl_w,
    input wire sda_w
);
    // ======================================================================
    // Bit timing, 80 ns clock period
    integer n;
    reg stall = 1'b0;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // The wait on the clock wire lets the target stretch the low phase.
    task pulse(output reg v);
        begin
            #40;
            scl_drv = 1'b1;
            for (n = 0; n < 2000 && scl_w !== 1'b1; n = n + 1) #8;
            if (n >= 2000)
                stall = 1'b1;
            #20;
            v = sda_w;
            #20;
            scl_drv = 1'b0;
        end
    endtask
    task start;
        begin
            // Callers return on a sampling edge; stepping 2 ns aside keeps every change off it.
            #2;
            sda_drv = 1'b0;
            #40;
            scl_drv = 1'b0;
        end
    endtask
    task send_byte(input [7:0] b);
        integer i;
        reg v;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                sda_drv = b[i];
                pulse(v);
            end
        end
    endtask
    task clock_ack(output reg v);
        begin
            #2;
            sda_drv = 1'b1;
            pulse(v);
        end
    endtask
    task stop;
        begin
            sda_drv = 1'b0;
            #40;
            scl_drv = 1'b1;
            #40;
            sda_drv = 1'b1;
            #40;
        end
    endtask
endmodule

//--- test/i2c_slave_address_match_test.sv
// Bench for the two-wire target: match table, random addresses, register checks.
// Assumes the bus master model and the bound checker.
`timescale 1ns/1ps
`include "i2c_target_defines.vh"
module i2c_slave_address_match_test;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, own, msk, b;
    reg [31:0] wdata = 32'h0, rd, lfsr = 32'h2A10E7C0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ack, m;
    wire awready, wready, bvalid, arready, rvalid, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
    wire scl_drv, sda_drv;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire scl_w = scl_drv & (scl_oe_n | scl_out);
    wire sda_w = sda_drv & (sda_oe_n | sda_out);
    integer fail_count = 0, checks = 0, n, i;
    reg [1:0] rr;
    reg [23:0] tbl [0:8];
    i2c_target uut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
    i2c_bus_master mst (.scl_drv(scl_drv), .sda_drv(sda_drv), .scl_w(scl_w), .sda_w(sda_w));
    initial forever #4 ref_clk = ~ref_clk;
    // ======================================================================
    // Helpers
    function [31:0] lfsr_next(input [31:0] x);
        lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function exp_match(input [7:0] o, input [7:0] k, input [7:0] v);
        exp_match = (v == 8'h00 && o[0]) || (k[0] && v[7:1] == k[7:1]) ||
            (((v[7:1] ^ o[7:1]) & (k[0] ? 7'h7F : ~k[7:1])) == 7'h00);
    endfunction
    task final_report;
        begin
            $display("checks %0d fail_count %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tmo;
        if (n >= 200) begin
            fail_count = fail_count + 1;
            final_report;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            @(negedge ref_clk);
            for (n = 0; n < 200 && !(awready && wready); n = n + 1) @(negedge ref_clk);
            tmo;
            @(posedge ref_clk);
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            @(negedge ref_clk);
            for (n = 0; n < 200 && !bvalid; n = n + 1) @(negedge ref_clk);
            tmo;
            // Ready comes a cycle late so that the answer has to stand while it waits.
            @(posedge ref_clk) bready <= 1'b1;
            @(posedge ref_clk) bready <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge ref_clk);
            araddr <= a;
            arvalid <= 1'b1;
            @(negedge ref_clk);
            for (n = 0; n < 200 && !arready; n = n + 1) @(negedge ref_clk);
            tmo;
            @(posedge ref_clk) arvalid <= 1'b0;
            @(negedge ref_clk);
            for (n = 0; n < 200 && !rvalid; n = n + 1) @(negedge ref_clk);
            tmo;
            rd = rdata;
            rr = rresp;
            @(posedge ref_clk) rready <= 1'b1;
            @(posedge ref_clk) rready <= 1'b0;
        end
    endtask
    // ======================================================================
    // Main sequence
    initial begin
        tbl[0] = 24'hA400A4;
        tbl[1] = 24'hA400A5;
        tbl[2] = 24'hA400A6;
        tbl[3] = 24'hA406A6;
        tbl[4] = 24'hA46D6C;
        tbl[5] = 24'hA46C6C;
        tbl[6] = 24'hA50000;
        tbl[7] = 24'hA40000;
        tbl[8] = 24'hF200F2;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            rd_reg(`ADDR_OWN_ID + 4 * i);
            cmp(rd, 32'h0);
        end
        rd_reg(8'h3C);
        cmp(rr, `AXI_SLVERR);
        wr(`ADDR_SHIFT_DATA, 8'h5A);
        rd_reg(`ADDR_SHIFT_DATA);
        cmp(rd, 32'h0);
        wr(`ADDR_IRQ_MASK, 8'h40);
        for (i = 0; i < 13; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            {own, msk, b} = tbl[i < 9 ? i : 0];
            if (i >= 9) begin
                own = {lfsr[6:0], 1'b0} | 8'h10;
                msk = 8'h00;
                b = lfsr[7] ? {own[7:1], lfsr[8]} : lfsr[15:8];
            end
            m = exp_match(own, msk, b);
            wr(`ADDR_OWN_ID, own);
            wr(`ADDR_ID_MASK, msk);
            wr(`ADDR_CTRL, {5'h0, b[0], 2'h0});
            rd_reg(`ADDR_ID_MASK);
            cmp(rd, {24'h0, msk});
            mst.start;
            mst.send_byte(b);
            repeat (10) @(posedge ref_clk);
            rd_reg(`ADDR_STATUS);
            cmp(rd & {25'h0, 5'h18, m, 1'b1}, {25'h0, m, m, 3'h0, m & b[0], m});
            cmp(irq, m);
            cmp(scl_oe_n, !m);
            if (m) begin
                rd_reg(`ADDR_SHIFT_DATA);
                cmp(rd, {24'h0, b});
            end
            mst.clock_ack(ack);
            cmp(ack, !m | b[0]);
            mst.stop;
            repeat (10) @(posedge ref_clk);
            rd_reg(`ADDR_STATUS);
            if (m) cmp(rd & 32'h41, 32'h40);
            wr(`ADDR_STATUS, 8'hC0);
            repeat (2) @(posedge ref_clk);
            cmp(irq, 1'b0);
            $display("case %0d done", i);
        end
        cmp(mst.stall, 1'b0);
        final_report;
    end
endmodule
